// >>> pmib_mgmt.sv
// management register bank of a dual-port phy with broadcast writes,
// per-port page select, soft reset and led blink after soft reset
// assumes an avalon-mm master with waitrequest; pins are synchronous to mclk
//
// The Avalon-MM slave port and the register offsets were left to the implementer.
module pmib_mgmt #(
	parameter logic [4:0] DEVICE_BASE_PORT = 5'h00,
	parameter int BLINK_LEN = pmib_pkg::BLINK_CYCLES
) (
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// reset pins
	input wire logic hard_reset_n,
	input wire logic soft_reset_n,
	// avalon-mm slave
	input wire logic [pmib_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// status
	output logic [1:0] led_blink,
	output logic bcast_active
);

	// sums a base port and an offset within the 5-bit port space
	function automatic logic [4:0] port_num(input logic [4:0] base, input logic [4:0] ofs);
		port_num = 5'(base + ofs);
	endfunction

	// one-hot enable of the addressed port
	function automatic logic [1:0] port_mask(input logic sel);
		port_mask = sel ? 2'b10 : 2'b01;
	endfunction

	localparam int BLINK_CW_L = pmib_pkg::BLINK_CW;
	localparam logic [BLINK_CW_L-1:0] BLINK_LOAD = BLINK_CW_L'(BLINK_LEN);

	logic rst;
	logic [6:0] clr_cnt_q;
	logic clr_busy;
	logic [1:0] rd_cnt_q;
	logic [15:0] rdata_q;
	logic [15:0] mem_rdata;
	logic bcast_q;
	logic [15:0] page_q [0:1];
	logic [1:0] led_cfg_q;
	logic srst_n_q;
	logic [BLINK_CW_L-1:0] blink_cnt_q [0:1];
	logic [1:0] led_q;

	// the hard reset pin clears everything the system reset does
	assign rst = sys_rst | ~hard_reset_n;

	// address decode
	wire [4:0] a_port = avs_address[9:5];
	wire [4:0] a_reg = avs_address[4:0];
	wire hit_a = a_port == port_num(DEVICE_BASE_PORT, pmib_pkg::PORT_OFS_A);
	wire hit_b = a_port == port_num(DEVICE_BASE_PORT, pmib_pkg::PORT_OFS_B);
	wire hit = hit_a | hit_b;
	wire psel = hit_b;
	wire [15:0] cur_page = page_q[psel];
	wire pg_main = cur_page == pmib_pkg::PAGE_MAIN;
	wire pg_ext = cur_page == pmib_pkg::PAGE_EXT;
	wire pg_known = pg_main | pg_ext;
	wire is_page = a_reg == pmib_pkg::REG_PAGE;
	wire [15:0] wd = avs_writedata[15:0];

	// transfer qualification; outside the clear sweep, writes complete in the cycle they are seen
	assign clr_busy = ~clr_cnt_q[6];
	assign avs_waitrequest = clr_busy | (avs_read & (rd_cnt_q != 2'(pmib_pkg::RD_LAT)));
	wire wr_take = avs_write & ~avs_waitrequest;
	wire wr_hit = wr_take & hit;

	// decoded register writes
	wire wr_reg = wr_hit & ~is_page & pg_known;
	wire wr_page = wr_hit & is_page;
	wire wr_bcast = wr_reg & pg_main & (a_reg == pmib_pkg::REG_BCAST);
	wire wr_ctrl = wr_reg & pg_main & (a_reg == pmib_pkg::REG_CTRL);
	wire wr_ledcfg = wr_reg & pg_ext & (a_reg == pmib_pkg::REG_LED_CFG);

	// ports reached by a write: both while broadcast is on, else the addressed one
	wire [1:0] wr_ports = bcast_q ? 2'b11 : port_mask(psel);

	// soft reset events: register bit 15 per port, pin release for both
	wire [1:0] srst_reg = (wr_ctrl & wd[pmib_pkg::SRST_BIT]) ? wr_ports : 2'b00;
	wire srst_pin_rel = soft_reset_n & ~srst_n_q;
	wire [1:0] srst_ev = srst_reg | {2{srst_pin_rel}};

	// memory side: sweep to zero after reset, then host writes
	wire [1:0] mem_we = clr_busy ? 2'b11 : (wr_reg ? wr_ports : 2'b00);
	wire [5:0] reg_idx = {pg_ext, a_reg};
	wire [5:0] mem_waddr = clr_busy ? clr_cnt_q[5:0] : reg_idx;
	// reset bit self-clears so a read never shows a stale request
	wire [15:0] wd_store = wr_ctrl ? (wd & ~(16'h0001 << pmib_pkg::SRST_BIT)) : wd;
	wire [15:0] mem_wdata = clr_busy ? pmib_pkg::REG_RST : wd_store;

	pmib_regmem u_mem (
		.mclk(mclk),
		.we(mem_we),
		.waddr(mem_waddr),
		.wdata(mem_wdata),
		.raddr(reg_idx),
		.rsel(psel),
		.rdata(mem_rdata)
	);

	// read data as seen by the host; broadcast bit reflects the device-wide flag
	wire rd_bcast = pg_main & (a_reg == pmib_pkg::REG_BCAST);
	wire [15:0] rd_word = rd_bcast ? {mem_rdata[15:1], bcast_q} : mem_rdata;
	wire [15:0] rd_val = !hit ? 16'h0000 : (is_page ? cur_page : (pg_known ? rd_word : 16'h0000));

	// clear sweep counter; the bus stalls until all words read as zero
	always_ff @(posedge mclk) begin
		if (rst) begin
			clr_cnt_q <= 7'h00;
		end else if (clr_busy) begin
			clr_cnt_q <= 7'(clr_cnt_q + 7'h01);
		end
	end

	// read pipeline: memory registers at the first edge, answer word at the second
	always_ff @(posedge mclk) begin
		if (rst || clr_busy || !avs_read || rd_cnt_q == 2'(pmib_pkg::RD_LAT)) begin
			rd_cnt_q <= 2'h0;
		end else begin
			rd_cnt_q <= 2'(rd_cnt_q + 2'h1);
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			rdata_q <= 16'h0000;
		end else if (avs_read && rd_cnt_q == 2'h1) begin
			rdata_q <= rd_val;
		end
	end

	assign avs_readdata = {16'h0000, rdata_q};

	// device-wide broadcast flag, written from either port
	always_ff @(posedge mclk) begin
		if (rst) begin
			bcast_q <= 1'b0;
		end else if (wr_bcast) begin
			bcast_q <= wd[pmib_pkg::BCAST_EN_BIT];
		end
	end

	assign bcast_active = bcast_q;

	// per-port page select; soft reset returns a port to the main page
	always_ff @(posedge mclk) begin
		for (int p = 0; p < 2; p++) begin
			if (rst || srst_ev[p] || !soft_reset_n) begin
				page_q[p] <= pmib_pkg::PAGE_RST;
			end else if (wr_page && wr_ports[p]) begin
				page_q[p] <= wd;
			end
		end
	end

	// shadow of the blink enable bit; it starts nothing until a soft reset
	always_ff @(posedge mclk) begin
		for (int p = 0; p < 2; p++) begin
			if (rst) begin
				led_cfg_q[p] <= 1'b0;
			end else if (wr_ledcfg && wr_ports[p]) begin
				led_cfg_q[p] <= wd[pmib_pkg::LED_BLINK_BIT];
			end
		end
	end

	// pin history for release detection
	always_ff @(posedge mclk) begin
		if (rst) begin
			srst_n_q <= 1'b1;
		end else begin
			srst_n_q <= soft_reset_n;
		end
	end

	// blink window: a pin release starts both ports together, so several
	// devices sharing the pin blink in step
	always_ff @(posedge mclk) begin
		for (int p = 0; p < 2; p++) begin
			if (rst) begin
				blink_cnt_q[p] <= '0;
				led_q[p] <= 1'b0;
			end else if (srst_ev[p] && led_cfg_q[p]) begin
				blink_cnt_q[p] <= BLINK_LOAD;
				led_q[p] <= 1'b1;
			end else if (blink_cnt_q[p] > BLINK_CW_L'(1)) begin
				blink_cnt_q[p] <= BLINK_CW_L'(blink_cnt_q[p] - BLINK_CW_L'(1));
			end else begin
				blink_cnt_q[p] <= '0;
				led_q[p] <= 1'b0;
			end
		end
	end

	assign led_blink = led_q;

	// checks

	property p_bcast_set;
		@(posedge mclk) disable iff (rst)
		(wr_bcast && wd[0]) |=> bcast_q;
	endproperty
	a_bcast_set: assert property (p_bcast_set) else $error("broadcast not enabled");

	property p_bcast_clr;
		@(posedge mclk) disable iff (rst)
		(wr_bcast && !wd[0]) |=> !bcast_q ##1 (!bcast_q || $past(wr_bcast));
	endproperty
	a_bcast_clr: assert property (p_bcast_clr) else $error("broadcast not disabled");

	property p_foreign;
		@(posedge mclk) disable iff (rst)
		(avs_write && !hit && !clr_busy) |-> (mem_we == 2'b00) && !wr_page;
	endproperty
	a_foreign: assert property (p_foreign) else $error("foreign port write landed");

	property p_page;
		@(posedge mclk) disable iff (rst)
		(wr_page && !srst_ev[psel] && soft_reset_n) |=> page_q[$past(psel)] == $past(wd);
	endproperty
	a_page: assert property (p_page) else $error("page select not held");

	property p_cfg_quiet;
		@(posedge mclk) disable iff (rst)
		(wr_ledcfg && srst_ev == 2'b00 && led_q == 2'b00) |=> led_q == 2'b00;
	endproperty
	a_cfg_quiet: assert property (p_cfg_quiet) else $error("blink without soft reset");

	property p_blink_len;
		@(posedge mclk) disable iff (rst)
		(srst_ev[0] && led_cfg_q[0]) |=> (blink_cnt_q[0] == BLINK_LOAD) && led_q[0];
	endproperty
	a_blink_len: assert property (p_blink_len) else $error("blink window not loaded");

	property p_pin_srst;
		@(posedge mclk) disable iff (rst)
		($rose(soft_reset_n) && led_cfg_q == 2'b11) |=> led_q == 2'b11;
	endproperty
	a_pin_srst: assert property (p_pin_srst) else $error("pin release did not blink");

	property p_reg_srst;
		@(posedge mclk) disable iff (rst)
		(wr_ctrl && wd[15] && !bcast_q && led_cfg_q[psel]) |=> led_q[$past(psel)];
	endproperty
	a_reg_srst: assert property (p_reg_srst) else $error("register soft reset lost");

	property p_rd_page;
		@(posedge mclk) disable iff (rst)
		(avs_read && !avs_waitrequest && hit && is_page) |-> avs_readdata == {16'h0000, cur_page};
	endproperty
	a_rd_page: assert property (p_rd_page) else $error("page read mismatch");

	property p_rd_lat;
		@(posedge mclk) disable iff (rst)
		(avs_read && !clr_busy && rd_cnt_q == 2'h0) |-> avs_waitrequest ##1 avs_waitrequest ##1 !avs_waitrequest;
	endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read latency wrong");

endmodule

// >>> pmib_pkg.sv
// constants shared by the management register block of a dual-port phy
// assumes a 125 mhz mclk and avalon word addressing {port[4:0], reg[4:0]}
package pmib_pkg;

	// register numbers
	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam logic [4:0] REG_LED_CFG = 5'h13;
	localparam logic [4:0] REG_BCAST = 5'h16;
	localparam logic [4:0] REG_PAGE = 5'h1f;

	// field positions
	localparam int SRST_BIT = 15;
	localparam int LED_BLINK_BIT = 11;
	localparam int BCAST_EN_BIT = 0;

	// page select values
	localparam logic [15:0] PAGE_MAIN = 16'h0000;
	localparam logic [15:0] PAGE_EXT = 16'h0001;

	// reset values
	localparam logic [15:0] PAGE_RST = 16'h0000;
	localparam logic [15:0] REG_RST = 16'h0000;

	// port numbers of the two ports relative to the device base port
	localparam logic [4:0] PORT_OFS_A = 5'h02;
	localparam logic [4:0] PORT_OFS_B = 5'h03;

	// bus geometry
	localparam int ADDR_W = 10;
	localparam int MEM_AW = 6;
	localparam int MEM_DEPTH = 64;
	localparam int RD_LAT = 2;

	// blink window after a soft reset
	localparam int CLK_MHZ = 125;
	localparam int BLINK_TIME_MS = 1000;
	localparam int BLINK_CYCLES = BLINK_TIME_MS * 1000 * CLK_MHZ;
	localparam int BLINK_CW = 27;

endpackage

// >>> pmib_regmem.sv
// register storage for both ports: one word holds {port b, port a} halves
// assumes the caller orders clear sweep and writes; read data are registered
module pmib_regmem (
	// clock
	input wire logic mclk,
	// write side
	input wire logic [1:0] we,
	input wire logic [pmib_pkg::MEM_AW-1:0] waddr,
	input wire logic [15:0] wdata,
	// read side
	input wire logic [pmib_pkg::MEM_AW-1:0] raddr,
	input wire logic rsel,
	output logic [15:0] rdata
);

	logic [31:0] mem [0:pmib_pkg::MEM_DEPTH-1];

	// each half is written on its own enable, so a broadcast hits both in one cycle
	always_ff @(posedge mclk) begin
		if (we[0]) begin
			mem[waddr][15:0] <= wdata;
		end
		if (we[1]) begin
			mem[waddr][31:16] <= wdata;
		end
	end

	// registered read of the selected port half
	always_ff @(posedge mclk) begin
		rdata <= rsel ? mem[raddr][31:16] : mem[raddr][15:0];
	end

endmodule

// >>> pmib_host.sv
// station management controller model: an avalon-mm master, one word per request
// assumes the device answers within the wait bound; hung flags a stalled request
module pmib_host (
	// clock
	input wire logic mclk,
	// avalon-mm master side
	output logic [9:0] avs_address,
	output logic avs_read,
	output logic avs_write,
	output logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// stall report
	output logic hung
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle bus at time zero
	initial begin
		avs_address = 10'h000;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h00000000;
		hung = 1'b0;
	end

	// the request goes out just after a rising edge and stands until the rising edge at
	// which waitrequest is sampled low; read data are taken at that edge, then one idle
	// edge passes so a following call never drives a strobe twice in one time step
	task automatic xfer(input logic w, input logic [4:0] p, input logic [4:0] r,
		input logic [15:0] d, output logic [15:0] q);
		int n;
		n = 0;
		q = 16'h0000;
		avs_address <= {p, r};
		avs_read <= !w;
		avs_write <= w;
		avs_writedata <= {16'h0000, d};
		@(posedge mclk);
		while (avs_waitrequest !== 1'b0 && n < 300) begin
			n++;
			@(posedge mclk);
		end
		q = avs_readdata[15:0];
		if (n >= 300) begin
			hung <= 1'b1;
		end
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		avs_writedata <= ~avs_writedata; // released data no longer shows the last value
		@(posedge mclk);
	endtask

	// required configuration script, optionally bracketed by broadcast on and off
	task automatic init(input logic [4:0] b, input logic bc);
		logic [15:0] v;
		if (bc) begin
			xfer(1'b1, b + 5'h02, 5'h1f, 16'h0000, v);
			xfer(1'b0, b + 5'h02, 5'h16, 16'h0000, v);
			xfer(1'b1, b + 5'h02, 5'h16, v | 16'h0001, v);
		end
		xfer(1'b1, b + 5'h02, 5'h1f, 16'h0000, v);
		xfer(1'b1, b + 5'h02, 5'h00, 16'h0800, v);
		xfer(1'b1, b + 5'h03, 5'h1f, 16'h0000, v);
		xfer(1'b1, b + 5'h03, 5'h00, 16'h0800, v);
		if (bc) begin
			xfer(1'b0, b + 5'h02, 5'h16, 16'h0000, v);
			xfer(1'b1, b + 5'h02, 5'h16, v & 16'hfffe, v);
		end
	endtask
endmodule

// >>> pmib_tb.sv
// self-checking bench: register traffic through the host model, reset pins and blink
// assumes a short blink window so that whole windows can be counted
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; \
	$display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [4:0] BASE = 5'h04;
	localparam logic [4:0] P0 = 5'h06;
	localparam logic [4:0] P1 = 5'h07;
	localparam int BL = 20;
	logic mclk, sys_rst, hard_reset_n, soft_reset_n, avs_read, avs_write;
	logic avs_waitrequest, bcast_active, hung;
	logic [9:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic [1:0] led_blink;
	logic [15:0] q;
	int mismatches, cmp_count;

	// design and controller model
	pmib_mgmt #(.DEVICE_BASE_PORT(BASE), .BLINK_LEN(BL)) i_pmib_mgmt (.mclk(mclk),
		.sys_rst(sys_rst), .hard_reset_n(hard_reset_n), .soft_reset_n(soft_reset_n),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .led_blink(led_blink),
		.bcast_active(bcast_active));
	pmib_host i_pmib_host (.mclk(mclk), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .hung(hung));

	// 125 mhz clock
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	task automatic summarize;
		if (mismatches == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// a stalled request ends the run at once
	task automatic wr(input logic [4:0] p, input logic [4:0] r, input logic [15:0] d);
		i_pmib_host.xfer(1'b1, p, r, d, q);
		if (hung) begin
			mismatches++;
			summarize();
		end
	endtask

	task automatic rd(input logic [4:0] p, input logic [4:0] r, input logic [15:0] e);
		i_pmib_host.xfer(1'b0, p, r, 16'h0000, q);
		if (hung) begin
			mismatches++;
			summarize();
		end
		`CHK(q, e)
	endtask

	// waits a few cycles for the window pattern m, then counts how long it stands
	task automatic blink(input logic [1:0] m);
		int n;
		n = 0;
		@(negedge mclk);
		for (int i = 0; i < 8 && led_blink !== m; i++)
			@(negedge mclk);
		while (led_blink === m && n < 100) begin
			n++;
			@(negedge mclk);
		end
		`CHK(n, BL)
		// hand the bus back on a rising edge
		@(posedge mclk);
	endtask

	// main sequence
	initial begin
		sys_rst = 1'b1;
		hard_reset_n = 1'b1;
		soft_reset_n = 1'b1;
		mismatches = 0;
		cmp_count = 0;
		repeat (10) @(posedge mclk);
		sys_rst <= 1'b0;
		i_pmib_host.init(BASE, 1'b1);
		rd(P0, 5'h00, 16'h0800);
		rd(P1, 5'h00, 16'h0800);
		`CHK(bcast_active, 1'b0)
		wr(P1, 5'h16, 16'h0001);
		`CHK(bcast_active, 1'b1)
		wr(P0, 5'h05, 16'h1234);
		rd(P1, 5'h05, 16'h1234);
		rd(BASE + 5'h06, 5'h05, 16'h0000);
		wr(P0, 5'h16, 16'h0000);
		`CHK(bcast_active, 1'b0)
		wr(P0, 5'h05, 16'haaaa);
		rd(P1, 5'h05, 16'h1234);
		// extended page per port, blink bit stored only
		wr(P0, 5'h1f, 16'h0001);
		wr(P0, 5'h13, 16'h0800);
		rd(P0, 5'h13, 16'h0800);
		rd(P1, 5'h1f, 16'h0000);
		rd(P0, 5'h1f, 16'h0001);
		`CHK(led_blink, 2'b00)
		wr(P0, 5'h1f, 16'h0000);
		rd(P0, 5'h13, 16'h0000);
		wr(P0, 5'h1f, 16'h0002);
		wr(P0, 5'h03, 16'h5555);
		rd(P0, 5'h03, 16'h0000);
		wr(P0, 5'h1f, 16'h0000);
		rd(P0, 5'h03, 16'h0000);
		// soft reset by register, then by pin; the window is watched from the request on
		fork
			wr(P0, 5'h00, 16'h9040);
			blink(2'b01);
		join
		rd(P0, 5'h00, 16'h1040);
		wr(P1, 5'h1f, 16'h0001);
		wr(P1, 5'h13, 16'h0800);
		soft_reset_n <= 1'b0;
		repeat (3) @(posedge mclk);
		soft_reset_n <= 1'b1;
		blink(2'b11);
		rd(P1, 5'h1f, 16'h0000);
		i_pmib_host.init(BASE, 1'b0);
		// broadcast soft reset reaches both ports, then the script again
		wr(P0, 5'h16, 16'h0001);
		fork
			wr(P0, 5'h00, 16'h9040);
			blink(2'b11);
		join
		i_pmib_host.init(BASE, 1'b1);
		rd(P1, 5'h00, 16'h0800);
		`CHK(bcast_active, 1'b0)
		// hard reset pin clears flag and storage
		wr(P1, 5'h16, 16'h0001);
		hard_reset_n <= 1'b0;
		repeat (2) @(posedge mclk);
		hard_reset_n <= 1'b1;
		@(posedge mclk);
		`CHK(bcast_active, 1'b0)
		i_pmib_host.init(BASE, 1'b0);
		rd(P1, 5'h05, 16'h0000);
		summarize();
	end
endmodule
